/* File: logic/pei_event_unit.sv */
// event interrupt unit of a tri-speed copper transceiver
// assumes the management register port is synchronous to clk_i and that
// event inputs are synchronous levels or one-cycle pulses from the core
//
// Operation
// - speed change on live link sets bit 15
// - link up or link loss sets bit 14
// - duplex change sets bit 13
// - crossover change sets bit 12
// - any channel polarity change sets bit 11
// - parallel detection fault sets bit 10
// - gigabit role resolution failure sets bit 9
// - no common ability sets bit 8
// - negotiation done but no link, bit 7
// - jabber start or end, 10M only, bit 6
// - next page received sets bit 5
// - negotiation complete sets bit 4
// - remote fault change sets bit 3
// - flags read-only, reset zero; bits 2:0 zero
// - mask bits 15..3 enable matching events
// - cleared mask suppresses; masks reset to zero
// - writing one to clear register clears flag
`timescale 1ns/100ps
module pei_event_unit (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // management register port
   input  wire logic [4:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [15:0] reg_wdata_i,
   output logic      [15:0] reg_rdata_o,
   output logic             reg_rvalid_o,
   // link state from the core
   input  wire logic        link_up_i,
   input  wire logic [1:0]  speed_i,
   input  wire logic        full_duplex_i,
   input  wire logic        xover_i,
   input  wire logic [3:0]  polarity_i,
   input  wire logic        par_det_fault_i,
   input  wire logic        ms_fault_i,
   input  wire logic        no_hcd_i,
   input  wire logic        an_no_link_i,
   input  wire logic        mode_10bt_i,
   input  wire logic        jabber_i,
   input  wire logic        next_page_i,
   input  wire logic        an_done_i,
   input  wire logic        remote_fault_i,
   // interrupt
   output logic             irq_o
);
   pei_flag_if u_fi ();

   logic [15:0] mask_q;
   logic [15:0] rdata_q;
   logic        rvalid_q;
   logic        irq_q;
   logic        primed_q;
   logic        prev_link_q;
   logic [1:0]  prev_speed_q;
   logic        prev_dplx_q;
   logic        prev_xover_q;
   logic [3:0]  prev_pol_q;
   logic        prev_jab_q;
   logic        prev_an_q;
   logic        prev_rf_q;

   logic        ev_speed;
   logic        ev_link;
   logic        ev_dplx;
   logic        ev_xover;
   logic        ev_pol;
   logic        ev_pdflt;
   logic        ev_mserr;
   logic        ev_nohcd;
   logic        ev_nolink;
   logic        ev_jabber;
   logic        ev_nxtpg;
   logic        ev_andone;
   logic        ev_remflt;
   logic        sel_status;
   logic        sel_mask;
   logic        sel_clear;
   logic        wr_mask;
   logic        wr_clear;
   logic [15:0] rd_mux;
   logic        irq_d;

   pei_flag_bank #(
      .W (pei_pkg::DATA_W)
   ) u_bank (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .fi    (u_fi.bank)
   );

   // change detectors wait one cycle after reset so stale history
   // cannot raise a spurious flag
   assign ev_speed  = primed_q & link_up_i & prev_link_q & (speed_i != prev_speed_q);
   assign ev_link   = primed_q & (link_up_i != prev_link_q);
   assign ev_dplx   = primed_q & (full_duplex_i != prev_dplx_q);
   assign ev_xover  = primed_q & (xover_i != prev_xover_q);
   assign ev_pol    = primed_q & (|(polarity_i ^ prev_pol_q));
   assign ev_pdflt  = par_det_fault_i;
   assign ev_mserr  = ms_fault_i & (speed_i == pei_pkg::SPEED_1000);
   assign ev_nohcd  = no_hcd_i;
   assign ev_nolink = an_no_link_i;
   assign ev_jabber = primed_q & mode_10bt_i & (jabber_i != prev_jab_q);
   assign ev_nxtpg  = next_page_i;
   assign ev_andone = primed_q & an_done_i & ~prev_an_q;
   assign ev_remflt = primed_q & (remote_fault_i != prev_rf_q);

   // event strobes in register bit order; reserved bits never set
   assign u_fi.set = {ev_speed, ev_link, ev_dplx, ev_xover, ev_pol, ev_pdflt,
                      ev_mserr, ev_nohcd, ev_nolink, ev_jabber, ev_nxtpg,
                      ev_andone, ev_remflt, 3'h0};

   // history of the level inputs for change detection
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         primed_q     <= 1'b0;
         prev_link_q  <= 1'b0;
         prev_speed_q <= pei_pkg::SPEED_RST;
         prev_dplx_q  <= 1'b0;
         prev_xover_q <= 1'b0;
         prev_pol_q   <= pei_pkg::POL_RST;
         prev_jab_q   <= 1'b0;
         prev_an_q    <= 1'b0;
         prev_rf_q    <= 1'b0;
      end
      else
      begin
         primed_q     <= 1'b1;
         prev_link_q  <= link_up_i;
         prev_speed_q <= speed_i;
         prev_dplx_q  <= full_duplex_i;
         prev_xover_q <= xover_i;
         prev_pol_q   <= polarity_i;
         prev_jab_q   <= jabber_i;
         prev_an_q    <= an_done_i;
         prev_rf_q    <= remote_fault_i;
      end
   end

   // register decode; status is read-only so writes to it are dropped
   assign sel_status = (reg_addr_i == pei_pkg::OFF_STATUS);
   assign sel_mask   = (reg_addr_i == pei_pkg::OFF_MASK);
   assign sel_clear  = (reg_addr_i == pei_pkg::OFF_CLEAR);
   assign wr_mask    = reg_wr_i & sel_mask;
   assign wr_clear   = reg_wr_i & sel_clear;

   // clear strobe lasts one cycle, so the clear register self-clears
   assign u_fi.clr = wr_clear ? (reg_wdata_i & pei_pkg::IMPL_BITS) : 16'h0000;

   // clear register reads zero because nothing is ever held in it;
   // unmapped offsets also read zero
   assign rd_mux = sel_status ? u_fi.flags :
                   sel_mask   ? mask_q     : 16'h0000;

   // mask register; reserved bits are forced low whatever is written
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mask_q <= pei_pkg::MASK_RST;
      else if (wr_mask)
         mask_q <= reg_wdata_i & pei_pkg::IMPL_BITS;
   end

   // read data registered: answer one cycle after the read strobe
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_q  <= pei_pkg::RDATA_RST;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rdata_q  <= reg_rd_i ? rd_mux : rdata_q;
         rvalid_q <= reg_rd_i;
      end
   end

   // interrupt from registered flags and mask; one cycle behind the flag,
   // traded for a glitch-free output pin
   assign irq_d = |(u_fi.flags & mask_q);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_q <= 1'b0;
      else
         irq_q <= irq_d;
   end

   assign reg_rdata_o  = rdata_q;
   assign reg_rvalid_o = rvalid_q;
   assign irq_o        = irq_q;

   // checks on the event path
   a_speed_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (primed_q && link_up_i && prev_link_q && speed_i != prev_speed_q)
         |=> u_fi.flags[pei_pkg::BIT_SPEED])
      else $error("speed change did not set its flag");

   a_link_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (primed_q && $changed(link_up_i)) |=> u_fi.flags[pei_pkg::BIT_LINK])
      else $error("link change did not set its flag");

   a_duplex_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (primed_q && $changed(full_duplex_i)) |=> u_fi.flags[pei_pkg::BIT_DUPLEX])
      else $error("duplex change did not set its flag");

   a_xover_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (primed_q && $changed(xover_i)) |=> u_fi.flags[pei_pkg::BIT_XOVER])
      else $error("crossover change did not set its flag");

   a_pol_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (primed_q && $changed(polarity_i)) |=> u_fi.flags[pei_pkg::BIT_POL])
      else $error("polarity change did not set its flag");

   a_pulse_flags: assert property (
      @(posedge clk_i) disable iff (rst_i)
      par_det_fault_i |=> u_fi.flags[pei_pkg::BIT_PDFLT])
      else $error("fault pulse did not set its flag");

   a_nohcd_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      no_hcd_i |=> u_fi.flags[pei_pkg::BIT_NOHCD])
      else $error("no common ability did not set its flag");

   a_nolink_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      an_no_link_i |=> u_fi.flags[pei_pkg::BIT_NOLINK])
      else $error("no link after negotiation did not set its flag");

   a_nxtpg_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      next_page_i |=> u_fi.flags[pei_pkg::BIT_NXTPG])
      else $error("next page did not set its flag");

   a_ms_gated: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!u_fi.flags[pei_pkg::BIT_MSERR] && !(ms_fault_i && speed_i == pei_pkg::SPEED_1000))
         |=> !u_fi.flags[pei_pkg::BIT_MSERR])
      else $error("role error flag rose without a gigabit fault");

   a_jabber_mode: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!mode_10bt_i && !u_fi.flags[pei_pkg::BIT_JABBER]) |=> !u_fi.flags[pei_pkg::BIT_JABBER])
      else $error("jabber flag rose outside 10M mode");

   a_an_edge: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (primed_q && $rose(an_done_i)) |=> u_fi.flags[pei_pkg::BIT_ANDONE])
      else $error("negotiation completion not flagged");

   a_remflt_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (primed_q && $changed(remote_fault_i)) |=> u_fi.flags[pei_pkg::BIT_REMFLT])
      else $error("remote fault change did not set its flag");

   a_resv_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      reg_rvalid_o |-> (reg_rdata_o[2:0] == 3'h0 && u_fi.flags[2:0] == 3'h0))
      else $error("reserved bits read nonzero");

   a_mask_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == pei_pkg::OFF_MASK)
         |=> mask_q == ($past(reg_wdata_i) & pei_pkg::IMPL_BITS))
      else $error("mask write not stored");

   a_mask_reset: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (mask_q == 16'h0000 && !irq_o))
      else $error("mask not zero after reset");

   a_clear_works: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == pei_pkg::OFF_CLEAR && reg_wdata_i[pei_pkg::BIT_NXTPG]
       && !next_page_i) |=> !u_fi.flags[pei_pkg::BIT_NXTPG])
      else $error("clear write left flag set");

   a_flag_holds: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (u_fi.flags[pei_pkg::BIT_REMFLT] && !u_fi.clr[pei_pkg::BIT_REMFLT])
         |=> u_fi.flags[pei_pkg::BIT_REMFLT])
      else $error("sticky flag dropped without a clear");

   a_irq_follows: assert property (
      @(posedge clk_i) disable iff (rst_i)
      |(u_fi.flags & mask_q) |=> irq_o ##0 $past(irq_d))
      else $error("interrupt not raised for enabled flag");

   a_irq_quiet: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !(|(u_fi.flags & mask_q)) |=> !irq_o)
      else $error("interrupt raised with no enabled flag");
endmodule : pei_event_unit

/* File: logic/pei_flag_bank.sv */
// event interrupt unit: bank of sticky event flags
// assumes set and clr are synchronous strobes on clk_i
`timescale 1ns/100ps
module pei_flag_bank #(
   parameter int W = pei_pkg::DATA_W
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   pei_flag_if.bank  fi
);
   logic [W-1:0] flags_q;
   logic [W-1:0] flags_d;

   // set beats clear so an event in the clearing cycle is kept
   assign flags_d = ((flags_q & ~fi.clr[W-1:0]) | fi.set[W-1:0])
                    & pei_pkg::IMPL_BITS[W-1:0];

   // flags hold until cleared; reserved bits can never rise
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         flags_q <= pei_pkg::STATUS_RST[W-1:0];
      else
         flags_q <= flags_d;
   end

   assign fi.flags = flags_q;
endmodule : pei_flag_bank

/* File: logic/pei_flag_if.sv */
// event interrupt unit: carrier between the controller and its flag bank
// assumes both ends share one clock
`timescale 1ns/100ps
interface pei_flag_if;
   logic [15:0] set;     // one-cycle event strobes
   logic [15:0] clr;     // one-cycle clear strobes from software
   logic [15:0] flags;   // sticky flags, registered

   modport bank (input set, input clr, output flags);
   modport ctrl (output set, output clr, input flags);
endinterface : pei_flag_if

/* File: logic/pei_pkg.sv */
// event interrupt unit: register offsets, field positions, reset values
// assumes a 5-bit management register address and 16-bit register words
package pei_pkg;
   localparam int          ADDR_W      = 5;
   localparam int          DATA_W      = 16;
   localparam int          POL_CH      = 4;

   // register offsets on the management register port
   localparam logic [4:0]  OFF_STATUS  = 5'h14;
   localparam logic [4:0]  OFF_MASK    = 5'h15;
   localparam logic [4:0]  OFF_CLEAR   = 5'h17;

   // flag positions, shared by status, mask and clear registers
   localparam int          BIT_SPEED   = 15;
   localparam int          BIT_LINK    = 14;
   localparam int          BIT_DUPLEX  = 13;
   localparam int          BIT_XOVER   = 12;
   localparam int          BIT_POL     = 11;
   localparam int          BIT_PDFLT   = 10;
   localparam int          BIT_MSERR   = 9;
   localparam int          BIT_NOHCD   = 8;
   localparam int          BIT_NOLINK  = 7;
   localparam int          BIT_JABBER  = 6;
   localparam int          BIT_NXTPG   = 5;
   localparam int          BIT_ANDONE  = 4;
   localparam int          BIT_REMFLT  = 3;

   // implemented flag bits; bits 2:0 are reserved and read as zero
   localparam logic [15:0] IMPL_BITS   = 16'hFFF8;
   localparam logic [15:0] STATUS_RST  = 16'h0000;
   localparam logic [15:0] MASK_RST    = 16'h0000;
   localparam logic [15:0] RDATA_RST   = 16'h0000;

   // speed encoding of the resolved link
   localparam logic [1:0]  SPEED_10    = 2'h0;
   localparam logic [1:0]  SPEED_100   = 2'h1;
   localparam logic [1:0]  SPEED_1000  = 2'h2;
   localparam logic [1:0]  SPEED_RST   = 2'h0;
   localparam logic [3:0]  POL_RST     = 4'h0;
endpackage : pei_pkg

/* File: tb/pei_event_unit_tb.sv */
// event interrupt unit: self-checking testbench driving the management port and
// core event inputs at the falling clock edge; assumes the unit's own assertions
`timescale 1ns/100ps
module pei_event_unit_tb;
   logic        clk_i;
   logic        rst_i;
   logic [4:0]  reg_addr_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic [15:0] reg_wdata_i;
   logic [15:0] reg_rdata_o;
   logic        reg_rvalid_o;
   logic        link_up_i, full_duplex_i, xover_i, par_det_fault_i, ms_fault_i;
   logic        no_hcd_i, an_no_link_i, mode_10bt_i, jabber_i, next_page_i;
   logic        an_done_i, remote_fault_i, irq_o;
   logic [1:0]  speed_i;
   logic [3:0]  polarity_i;
   int          num_errors;
   int          n_tests;

   pei_event_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .link_up_i(link_up_i),
      .speed_i(speed_i), .full_duplex_i(full_duplex_i), .xover_i(xover_i),
      .polarity_i(polarity_i), .par_det_fault_i(par_det_fault_i), .ms_fault_i(ms_fault_i),
      .no_hcd_i(no_hcd_i), .an_no_link_i(an_no_link_i), .mode_10bt_i(mode_10bt_i),
      .jabber_i(jabber_i), .next_page_i(next_page_i), .an_done_i(an_done_i),
      .remote_fault_i(remote_fault_i), .irq_o(irq_o));

   // free-running 20 MHz core clock
   always
   begin
      #25 clk_i = ~clk_i;
   end

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out

   // compare tasks, one per result kind; x never matches
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk16

   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk1

   // one-cycle write strobe, taken at the rising edge in between
   task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
      reg_addr_i  = a;
      reg_wdata_i = d;
      reg_wr_i    = 1'b1;
      @(negedge clk_i);
      reg_wr_i    = 1'b0;
   endtask : reg_write

   // one-cycle read strobe, answer awaited under a bounded count
   task automatic read_chk(input logic [4:0] a, input logic [15:0] exp);
      bit ok;
      ok         = 1'b0;
      reg_addr_i = a;
      reg_rd_i   = 1'b1;
      for (int i = 0; i < 4 && !ok; i++)
      begin
         @(negedge clk_i);
         reg_rd_i = 1'b0;
         ok       = (reg_rvalid_o === 1'b1);
      end
      if (!ok)
      begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         close_out();
      end
      else
      begin
         chk16(reg_rdata_o, exp);
         // idle cycle so a following read does not re-raise the strobe at once
         @(negedge clk_i);
      end
   endtask : read_chk

   // raise the event behind flag b; pulses last exactly one cycle
   task automatic fire(input int b);
      case (b)
         15: speed_i = pei_pkg::SPEED_1000;
         14: link_up_i = ~link_up_i;
         13: full_duplex_i = ~full_duplex_i;
         12: xover_i = ~xover_i;
         11: polarity_i[2] = ~polarity_i[2];
         10: par_det_fault_i = 1'b1;
         9: ms_fault_i = 1'b1;
         8: no_hcd_i = 1'b1;
         7: an_no_link_i = 1'b1;
         6: jabber_i = ~jabber_i;
         5: next_page_i = 1'b1;
         4: an_done_i = 1'b1;
         default: remote_fault_i = ~remote_fault_i;
      endcase
      @(negedge clk_i);
      {par_det_fault_i, ms_fault_i, no_hcd_i, an_no_link_i, next_page_i} = 5'h00;
   endtask : fire

   // main sequence
   initial
   begin
      clk_i = 1'b0; rst_i = 1'b1; reg_addr_i = 5'h00; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
      reg_wdata_i = 16'h0000; link_up_i = 1'b0; speed_i = pei_pkg::SPEED_10;
      full_duplex_i = 1'b0; xover_i = 1'b0; polarity_i = 4'h0; par_det_fault_i = 1'b0;
      ms_fault_i = 1'b0; no_hcd_i = 1'b0; an_no_link_i = 1'b0; mode_10bt_i = 1'b0;
      jabber_i = 1'b0; next_page_i = 1'b0; an_done_i = 1'b0; remote_fault_i = 1'b0;
      num_errors = 0; n_tests = 0;
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      // reset values, refused and reserved places
      chk1(irq_o, 1'b0);
      read_chk(pei_pkg::OFF_STATUS, 16'h0000);
      read_chk(pei_pkg::OFF_MASK, 16'h0000);
      reg_write(pei_pkg::OFF_STATUS, 16'hFFFF);
      read_chk(pei_pkg::OFF_STATUS, 16'h0000);
      reg_write(pei_pkg::OFF_MASK, 16'hFFFF);
      read_chk(pei_pkg::OFF_MASK, 16'hFFF8);
      read_chk(pei_pkg::OFF_CLEAR, 16'h0000);
      read_chk(5'h10, 16'h0000);
      $display("test registers done");
      // bring the link up at 100M in 10M-style jabber mode, then start clean
      link_up_i = 1'b1; speed_i = pei_pkg::SPEED_100; mode_10bt_i = 1'b1;
      repeat (3) @(negedge clk_i);
      reg_write(pei_pkg::OFF_CLEAR, 16'hFFF8);
      @(negedge clk_i);
      read_chk(pei_pkg::OFF_STATUS, 16'h0000);
      // every event sets its own flag, holds it, drives irq, and is cleared
      for (int b = 15; b >= 3; b--)
      begin
         fire(b);
         repeat (3) @(negedge clk_i);
         chk1(irq_o, 1'b1);
         read_chk(pei_pkg::OFF_STATUS, 16'h0001 << b);
         reg_write(pei_pkg::OFF_CLEAR, 16'h0001 << b);
         @(negedge clk_i);
         chk1(irq_o, 1'b0);
         read_chk(pei_pkg::OFF_STATUS, 16'h0000);
      end
      $display("test events done");
      // refused events: jabber outside 10M mode, role error below 1G, speed with no link
      mode_10bt_i = 1'b0;
      jabber_i    = ~jabber_i;
      speed_i     = pei_pkg::SPEED_100;
      @(negedge clk_i);
      fire(pei_pkg::BIT_MSERR);
      repeat (3) @(negedge clk_i);
      read_chk(pei_pkg::OFF_STATUS, 16'h0000);
      $display("test refusals done");
      // masked event is flagged but silent until its enable is set
      reg_write(pei_pkg::OFF_MASK, 16'h0000);
      fire(pei_pkg::BIT_NOHCD);
      repeat (3) @(negedge clk_i);
      chk1(irq_o, 1'b0);
      read_chk(pei_pkg::OFF_STATUS, 16'h0100);
      reg_write(pei_pkg::OFF_MASK, 16'h0100);
      repeat (2) @(negedge clk_i);
      chk1(irq_o, 1'b1);
      reg_write(pei_pkg::OFF_MASK, 16'h0000);
      repeat (2) @(negedge clk_i);
      chk1(irq_o, 1'b0);
      reg_write(pei_pkg::OFF_CLEAR, 16'h0100);
      read_chk(pei_pkg::OFF_STATUS, 16'h0000);
      $display("test masking done");
      // a reset in mid-run must wipe a set flag and its enable and drop irq
      reg_write(pei_pkg::OFF_MASK, 16'h0020);
      fire(pei_pkg::BIT_NXTPG);
      repeat (3) @(negedge clk_i);
      chk1(irq_o, 1'b1);
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      chk1(irq_o, 1'b0);
      read_chk(pei_pkg::OFF_STATUS, 16'h0000);
      read_chk(pei_pkg::OFF_MASK, 16'h0000);
      $display("test mid-run reset done");
      close_out();
   end
endmodule : pei_event_unit_tb
